// ==== common/sbs_consts.svh ====
// constants for the burst sram control-input front end
// Behaviour
// - device samples the whole address on each enabled load edge
// - low two address bits seed burst counter
// - byte written when its select and write low
// - write enable low starts write, gated by enable
// - advance high with enable low steps counter
// - advance low loads a fresh address
// - controller loads new address after deselect; the controller copies I_REQ_ADV to advance_load even then
// - clock enable high freezes all link input capture; the order strap is still caught during reset
// - select needs sel1 low, sel2 high, sel3 low
// - clock enable high stretches cycle, keeps selection
// - strap low linear, high interleaved order
// - read data follows the previous sampled address
// - data outputs off on writes and deselect
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
// ***********************************************
// burst counter
// ***********************************************
`define SBS_STEP_ZERO 2'h0
`define SBS_STEP_ONE 2'h1
`define SBS_GRP_LSB 2
`define SBS_ORDER_LINEAR 1'b0
// ***********************************************
// link idle levels and buffer
// ***********************************************
`define SBS_OFF 1'b0
`define SBS_ON 1'b1
`define SBS_BUF_FULL 2'h2
`endif

// ==== common/sbs_pkg.sv ====
// shared types of the burst sram front end
package sbs_pkg;
  // kind of access held for a burst, gray along idle-read-write
  typedef enum logic [1:0] {
    SBS_IDLE = 2'h0,
    SBS_RD = 2'h1,
    SBS_WR = 2'h3
  } sbs_acc_t;
endpackage

// ==== common/sbs_if.sv ====
// link between the memory controller and the burst sram
`timescale 1ns/1ps
interface sbs_if #(parameter int AW = 18, parameter int NB = 4, parameter int BW = 9);
  logic [AW-1:0] addr;
  logic [NB-1:0] byte_write_sel_n;
  logic write_en_n;
  logic advance_load;
  logic clock_en_n;
  logic chip_sel1_n;
  logic chip_sel2;
  logic chip_sel3_n;
  logic [NB*BW-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [NB*BW-1:0] dq_dev;
  logic dq_dev_oe;
  logic [NB*BW-1:0] dq;
  // resolved data wire, the device wins when it drives
  assign dq = dq_dev_oe ? dq_dev : dq_ctl;
  modport dev (
    input addr, byte_write_sel_n, write_en_n, advance_load, clock_en_n,
    input chip_sel1_n, chip_sel2, chip_sel3_n, dq,
    output dq_dev, dq_dev_oe
  );
  modport ctl (
    output addr, byte_write_sel_n, write_en_n, advance_load, clock_en_n,
    output chip_sel1_n, chip_sel2, chip_sel3_n, dq_ctl, dq_ctl_oe,
    input dq
  );
endinterface

// ==== design/sbs_sram_dev.sv ====
// burst sram end: registered control inputs, burst counter, storage
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_sram_dev #(
  parameter int AW = 18,
  parameter int NB = 4,
  parameter int BW = 9
) (
  input wire logic I_CLK,          // system clock
  input wire logic I_SYS_RST,      // sync reset, high
  input wire logic I_BURST_ORDER,  // order strap, low linear
  output logic O_SELECTED,         // access in progress
  output logic O_BURST_ACTIVE,     // last edge advanced
  sbs_if.dev LINK                  // controller link
);
  localparam int DW = NB * BW;

  // ***********************************************
  // storage and state
  // ***********************************************
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic order;
  sbs_pkg::sbs_acc_t acc;
  logic [AW-1:0] base;
  logic [1:0] step;
  logic wr_pend;
  logic [AW-1:0] wr_addr;
  logic [NB-1:0] wr_sel_n;
  logic en;
  logic ld;
  logic sel;
  sbs_pkg::sbs_acc_t next_acc;
  logic [AW-1:0] next_base;
  logic [1:0] next_step;
  logic [AW-1:0] acc_addr;
  logic [DW-1:0] rd_word;

  // ***********************************************
  // decoding helpers
  // ***********************************************
  // all three selects must agree
  function automatic logic chip_sel(input logic c1n, input logic c2, input logic c3n);
    return !c1n && c2 && !c3n;
  endfunction

  // offset within the four-word group
  function automatic logic [1:0] burst_offs(input logic [1:0] start, input logic [1:0] stp,
                                            input logic ilv);
    logic [1:0] lin;
    lin = 2'(start + stp);
    return ilv ? (start ^ stp) : lin;
  endfunction

  // merge a pending write into a word being read
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                          input logic [NB-1:0] bsel_n);
    logic [DW-1:0] res;
    res = old;
    for (int b = 0; b < NB; b++) begin
      if (!bsel_n[b]) begin
        res[b*BW +: BW] = nw[b*BW +: BW];
      end
    end
    return res;
  endfunction

  // ***********************************************
  // next access decode
  // ***********************************************
  // load or advance, decided from the sampled pins
  always_comb begin
    en = !LINK.clock_en_n;
    ld = !LINK.advance_load;
    sel = chip_sel(LINK.chip_sel1_n, LINK.chip_sel2, LINK.chip_sel3_n);
    next_acc = acc;
    next_base = base;
    next_step = step;
    if (ld) begin
      next_base = LINK.addr;
      next_step = `SBS_STEP_ZERO;
      if (!sel) begin
        next_acc = sbs_pkg::SBS_IDLE;
      end else if (!LINK.write_en_n) begin
        next_acc = sbs_pkg::SBS_WR;
      end else begin
        next_acc = sbs_pkg::SBS_RD;
      end
    end else if (acc != sbs_pkg::SBS_IDLE) begin
      next_step = 2'(step + `SBS_STEP_ONE);
    end
    acc_addr = {next_base[AW-1:`SBS_GRP_LSB], burst_offs(next_base[1:0], next_step, order)};
  end

  // read word with a pending write merged in
  always_comb begin
    rd_word = mem[acc_addr];
    if (wr_pend && (wr_addr == acc_addr)) begin
      rd_word = merge(rd_word, LINK.dq, wr_sel_n);
    end
  end

  // ***********************************************
  // strap capture
  // ***********************************************
  // order strap caught while reset is held
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      order <= I_BURST_ORDER;
    end
  end

  // ***********************************************
  // access state
  // ***********************************************
  // kind, group base and step, frozen while enable is high
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      acc <= sbs_pkg::SBS_IDLE;
      base <= '0;
      step <= `SBS_STEP_ZERO;
    end else if (en) begin
      acc <= next_acc;
      base <= next_base;
      step <= next_step;
    end
  end

  // status flags
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_SELECTED <= `SBS_OFF;
      O_BURST_ACTIVE <= `SBS_OFF;
    end else if (en) begin
      O_SELECTED <= (next_acc != sbs_pkg::SBS_IDLE);
      O_BURST_ACTIVE <= !ld && (next_acc != sbs_pkg::SBS_IDLE);
    end
  end

  // ***********************************************
  // write path
  // ***********************************************
  // address and byte selects now, data at the next enabled edge
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      wr_pend <= `SBS_OFF;
      wr_addr <= '0;
      wr_sel_n <= '1;
    end else if (en) begin
      wr_pend <= (next_acc == sbs_pkg::SBS_WR);
      wr_addr <= acc_addr;
      wr_sel_n <= LINK.byte_write_sel_n;
    end
  end

  // commit of the data phase, per byte lane
  always_ff @(posedge I_CLK) begin
    if (!I_SYS_RST && en && wr_pend) begin
      for (int b = 0; b < NB; b++) begin
        if (!wr_sel_n[b]) begin
          mem[wr_addr][b*BW +: BW] <= LINK.dq[b*BW +: BW];
        end
      end
    end
  end

  // ***********************************************
  // read path
  // ***********************************************
  // data for the address sampled at this edge, driven next cycle
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      LINK.dq_dev <= '0;
      LINK.dq_dev_oe <= `SBS_OFF;
    end else if (en) begin
      case (next_acc)
        sbs_pkg::SBS_RD: begin
          LINK.dq_dev <= rd_word;
          LINK.dq_dev_oe <= `SBS_ON;
        end
        sbs_pkg::SBS_WR: begin
          LINK.dq_dev_oe <= `SBS_OFF;
        end
        sbs_pkg::SBS_IDLE: begin
          LINK.dq_dev_oe <= `SBS_OFF;
        end
        default: begin
          LINK.dq_dev_oe <= `SBS_OFF;
        end
      endcase
    end
  end
endmodule // sbs_sram_dev

// ==== design/sbs_sram_ctl.sv ====
// memory controller end: issues accesses, buffers read data
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_sram_ctl #(
  parameter int AW = 18,
  parameter int NB = 4,
  parameter int BW = 9
) (
  input wire logic I_CLK,                 // system clock
  input wire logic I_SYS_RST,             // sync reset, high
  input wire logic I_REQ_VALID,           // request present
  output logic O_REQ_READY,               // request taken this edge
  input wire logic I_REQ_WRITE,           // write, else read
  input wire logic I_REQ_ADV,             // continue burst
  input wire logic [AW-1:0] I_REQ_ADDR,   // word address
  input wire logic [NB*BW-1:0] I_REQ_WDATA, // write data
  input wire logic [NB-1:0] I_REQ_BYTE_EN, // byte enables, high
  output logic O_RD_VALID,                // read word present
  input wire logic I_RD_READY,            // read word taken
  output logic [NB*BW-1:0] O_RD_DATA,     // read word
  sbs_if.ctl LINK                         // sram link
);
  localparam int DW = NB * BW;

  // ***********************************************
  // state
  // ***********************************************
  sbs_pkg::sbs_acc_t st1;
  sbs_pkg::sbs_acc_t st2;
  sbs_pkg::sbs_acc_t last;
  sbs_pkg::sbs_acc_t next_st1;
  sbs_pkg::sbs_acc_t next_st2;
  logic [DW-1:0] st1_wdata;
  logic skid_v;
  logic [DW-1:0] skid_d;
  logic en;
  logic push;
  logic pop;
  logic [1:0] next_cnt;
  logic next_stall;

  // ***********************************************
  // pipeline decode
  // ***********************************************
  // what the pins carry next and whether the buffer forces a stall
  always_comb begin
    en = !LINK.clock_en_n;
    push = en && (st2 == sbs_pkg::SBS_RD);
    pop = O_RD_VALID && I_RD_READY;
    next_cnt = 2'(2'(O_RD_VALID) + 2'(skid_v) + 2'(push) - 2'(pop));
    next_st2 = en ? st1 : st2;
    next_st1 = st1;
    if (en) begin
      if (!I_REQ_VALID) begin
        next_st1 = sbs_pkg::SBS_IDLE;
      end else if (I_REQ_ADV) begin
        next_st1 = last;
      end else begin
        next_st1 = I_REQ_WRITE ? sbs_pkg::SBS_WR : sbs_pkg::SBS_RD;
      end
    end
    next_stall = (next_cnt == `SBS_BUF_FULL) && (next_st2 == sbs_pkg::SBS_RD);
  end

  // ***********************************************
  // link pins
  // ***********************************************
  // a new cycle goes out only after the last one was taken
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      LINK.addr <= '0;
      LINK.byte_write_sel_n <= '1;
      LINK.write_en_n <= `SBS_ON;
      LINK.advance_load <= `SBS_OFF;
      LINK.chip_sel1_n <= `SBS_ON;
      LINK.chip_sel2 <= `SBS_OFF;
      LINK.chip_sel3_n <= `SBS_ON;
      st1 <= sbs_pkg::SBS_IDLE;
      st1_wdata <= '0;
      last <= sbs_pkg::SBS_IDLE;
    end else if (en) begin
      st1 <= next_st1;
      st1_wdata <= I_REQ_WDATA;
      LINK.write_en_n <= (next_st1 != sbs_pkg::SBS_WR);
      LINK.byte_write_sel_n <= (next_st1 == sbs_pkg::SBS_WR) ? ~I_REQ_BYTE_EN : '1;
      if (I_REQ_VALID) begin
        LINK.addr <= I_REQ_ADDR;
        LINK.advance_load <= I_REQ_ADV;
        LINK.chip_sel1_n <= `SBS_OFF;
        LINK.chip_sel2 <= `SBS_ON;
        LINK.chip_sel3_n <= `SBS_OFF;
        if (!I_REQ_ADV) begin
          last <= next_st1;
        end
      end else begin
        LINK.advance_load <= `SBS_OFF;
        LINK.chip_sel1_n <= `SBS_ON;
        last <= sbs_pkg::SBS_IDLE;
      end
    end
  end

  // clock enable and request ready share one decision
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      LINK.clock_en_n <= `SBS_OFF;
      O_REQ_READY <= `SBS_ON;
    end else begin
      LINK.clock_en_n <= next_stall;
      O_REQ_READY <= !next_stall;
    end
  end

  // ***********************************************
  // data phase
  // ***********************************************
  // write data driven the cycle after its address is sampled
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st2 <= sbs_pkg::SBS_IDLE;
      LINK.dq_ctl <= '0;
      LINK.dq_ctl_oe <= `SBS_OFF;
    end else if (en) begin
      st2 <= next_st2;
      LINK.dq_ctl <= st1_wdata;
      LINK.dq_ctl_oe <= (st1 == sbs_pkg::SBS_WR);
    end
  end

  // two-entry read buffer: output stage plus one skid word
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_RD_VALID <= `SBS_OFF;
      O_RD_DATA <= '0;
      skid_v <= `SBS_OFF;
      skid_d <= '0;
    end else if (pop || !O_RD_VALID) begin
      if (skid_v) begin
        O_RD_DATA <= skid_d;
        O_RD_VALID <= `SBS_ON;
        skid_v <= push;
        if (push) begin
          skid_d <= LINK.dq;
        end
      end else begin
        O_RD_VALID <= push;
        if (push) begin
          O_RD_DATA <= LINK.dq;
        end
      end
    end else if (push) begin
      skid_v <= `SBS_ON;
      skid_d <= LINK.dq;
    end
  end
endmodule // sbs_sram_ctl

// ==== verif/sbs_link_checker.sv ====
// link checker between the controller end and the sram end
`timescale 1ns/1ps
module sbs_link_checker #(
  parameter int AW = 18,
  parameter int NB = 4,
  parameter int BW = 9
) (
  input wire logic I_CLK,                // system clock
  input wire logic I_SYS_RST,            // sync reset, high
  input wire logic write_en_n,           // write, low
  input wire logic advance_load,         // advance high, load low
  input wire logic clock_en_n,           // edge recognised, low
  input wire logic chip_sel1_n,          // select one, low
  input wire logic chip_sel2,            // select two, high
  input wire logic chip_sel3_n,          // select three, low
  input wire logic dq_ctl_oe,            // controller drives data
  input wire logic [NB*BW-1:0] dq_dev,   // sram data out
  input wire logic dq_dev_oe             // sram drives data
);
  logic sel;
  // decoded select combination
  assign sel = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // ***********************************************
  // access kinds seen at an enabled edge
  // ***********************************************
  sequence ld_rd; !clock_en_n && sel && !advance_load && write_en_n; endsequence
  sequence ld_wr; !clock_en_n && sel && !advance_load && !write_en_n; endsequence
  sequence desel; !clock_en_n && !sel && !advance_load; endsequence
  // ***********************************************
  // assertions
  // ***********************************************
  AST_NO_CONTENTION: assert property (!(dq_dev_oe && dq_ctl_oe))
    else $error("both ends drive the data bus");
  AST_READ_FLOW: assert property (ld_rd |=> dq_dev_oe)
    else $error("read data missing after read load");
  AST_WRITE_OFF: assert property (ld_wr |=> !dq_dev_oe)
    else $error("sram drives data in write cycle");
  AST_WRITE_DATA: assert property (ld_wr |=> dq_ctl_oe)
    else $error("write data not driven after write load");
  AST_DESEL_OFF: assert property (desel |=> !dq_dev_oe)
    else $error("sram drives data while deselected");
  AST_FREEZE: assert property (clock_en_n |=> $stable(dq_dev_oe) && $stable(dq_dev))
    else $error("sram output moved on masked edge");
  AST_RESET_IDLE: assert property ($fell(I_SYS_RST) |-> !sel && write_en_n && !clock_en_n)
    else $error("link not idle after reset");
  AST_LOAD_AFTER_DESEL: assert property (desel ##1 (!clock_en_n && sel) |-> !advance_load)
    else $error("advance right after deselect");
endmodule // sbs_link_checker

// ==== verif/sync_burst_sram_control_inputs_tb.sv ====
// self-checking bench of both burst sram ends joined by one link
`timescale 1ns/1ps
module sync_burst_sram_control_inputs_tb;
  logic clk, sys_rst, strap, valid, wr, adv, rd_rdy, rd_valid, req_rdy, sel, bact;
  logic [17:0] addr;
  logic [35:0] wdata, rd_data;
  logic [3:0] be;
  logic [35:0] mem [int];
  logic [35:0] eq [$];
  logic [35:0] rq [$];
  int n_fail = 0;
  int check_count = 0;
  sbs_if link ();
  sbs_sram_ctl u_sbs_sram_ctl (.I_CLK(clk), .I_SYS_RST(sys_rst),
    .I_REQ_VALID(valid), .O_REQ_READY(req_rdy), .I_REQ_WRITE(wr), .I_REQ_ADV(adv),
    .I_REQ_ADDR(addr), .I_REQ_WDATA(wdata), .I_REQ_BYTE_EN(be), .O_RD_VALID(rd_valid),
    .I_RD_READY(rd_rdy), .O_RD_DATA(rd_data), .LINK(link));
  sbs_sram_dev u_sbs_sram_dev (.I_CLK(clk), .I_SYS_RST(sys_rst),
    .I_BURST_ORDER(strap), .O_SELECTED(sel), .O_BURST_ACTIVE(bact), .LINK(link));
  sbs_link_checker u_sbs_link_checker (.I_CLK(clk),
    .I_SYS_RST(sys_rst), .write_en_n(link.write_en_n), .advance_load(link.advance_load),
    .clock_en_n(link.clock_en_n), .chip_sel1_n(link.chip_sel1_n), .chip_sel2(link.chip_sel2),
    .chip_sel3_n(link.chip_sel3_n), .dq_ctl_oe(link.dq_ctl_oe), .dq_dev(link.dq_dev),
    .dq_dev_oe(link.dq_dev_oe));
  // ***********************************************
  // clock, read capture, watchdog
  // ***********************************************
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // collect read words as they are taken
  always @(posedge clk) begin
    if (!sys_rst && rd_valid === 1'b1 && rd_rdy) rq.push_back(rd_data);
  end
  // cut a hang short
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single status flag compare
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // burst address from start lane and step
  function automatic logic [17:0] la(logic [17:0] b, logic [1:0] s, logic [1:0] k);
    return {b[17:2], strap ? s ^ k : s + k};
  endfunction
  task automatic do_reset(input logic o);
    @(negedge clk);
    sys_rst = 1;
    strap = o;
    valid = 0;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    @(negedge clk);
  endtask
  // one request, held until taken; model updated
  task automatic req(input logic w, a, input logic [17:0] ad, input logic [35:0] d,
                     input logic [3:0] b);
    int n;
    logic [35:0] m;
    @(negedge clk);
    valid = 1; wr = w; adv = a; addr = ad; wdata = d; be = b;
    n = 0;
    while (req_rdy !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    m = mem.exists(ad) ? mem[ad] : 'X;
    if (w) begin
      for (int i = 0; i < 4; i++) if (b[i]) m[i*9 +: 9] = d[i*9 +: 9];
      mem[ad] = m;
    end else eq.push_back(m);
  endtask
  task automatic idle;
    @(negedge clk);
    valid = 0;
  endtask
  task automatic drain(input string nm);
    int n;
    logic [35:0] e;
    idle();
    while (eq.size() > 0) begin
      n = 0;
      while (rq.size() == 0 && n < 40) begin
        @(negedge clk);
        n++;
      end
      e = eq.pop_front();
      if (rq.size() == 0) chk('X, e);
      else chk(rq.pop_front(), e);
    end
    $display("test %s done", nm);
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_bytes;
    req(1, 0, 18'h00100, 36'h123456789, 4'hF);
    req(1, 0, 18'h00100, 36'hABCDEF012, 4'h5);
    req(1, 0, 18'h00100, 36'hFFFFFFFFF, 4'h0);
    req(0, 0, 18'h00100, '0, 4'h0);
    idle();
    req(0, 0, 18'h00100, '0, 4'h0);
    drain("bytes");
  endtask
  task automatic t_burst(input logic o, input logic [17:0] b, input logic [35:0] d);
    do_reset(o);
    for (int k = 0; k < 4; k++) req(1, k != 0, la(b, 2'h1, k[1:0]), d + k, 4'hF);
    for (int k = 0; k < 4; k++) req(0, 0, {b[17:2], k[1:0]}, '0, 4'h0);
    for (int k = 0; k < 4; k++) req(0, k != 0, la(b, 2'h2, k[1:0]), '0, 4'h0);
    idle();
    chk_flag(sel, 1'b1);
    chk_flag(bact, 1'b1);
    drain("burst");
    chk_flag(sel, 1'b0);
    chk_flag(bact, 1'b0);
  endtask
  task automatic t_stall;
    @(negedge clk);
    rd_rdy = 0;
    fork
      for (int k = 0; k < 6; k++) req(0, 0, {16'h0080, k[1:0]}, '0, 4'h0);
      begin
        repeat (12) @(negedge clk);
        chk_flag(req_rdy, 1'b0);
        chk_flag(link.clock_en_n, 1'b1);
        chk_flag(sel, 1'b1);
        rd_rdy = 1;
      end
    join
    drain("stall");
  endtask
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    sys_rst = 1; strap = 0; valid = 0; wr = 0; adv = 0;
    addr = '0; wdata = '0; be = '0; rd_rdy = 1;
    t_burst(1'b0, 18'h00200, 36'h111111110);
    t_bytes();
    t_burst(1'b1, 18'h00344, 36'h2468ACE00);
    t_stall();
    report_and_stop();
  end
endmodule // sync_burst_sram_control_inputs_tb
